// ### design/fps_defs.vh
// Overview of operation
// - end on-time when sense reaches 0.65V
// - offset source only above 2.9V, high line
// - ignore current sense 350ns after turn-on
// - auto fault: burst retry at turn-on level
// - latch fault: clears after POWER_DOWN_RESET_LEVEL then turn-on
// - overload 4.2V beyond delay stops gate
// - overload releases at fourth turn-off crossing
// - 4.2V over 16ms, supply below 10V trips
// - supply overvoltage off until next turn-on
// - new on-time on aux falling edge 0.05V
// - sample aux overvoltage 2us after turn-off
// - four consecutive aux overvoltage cycles trip
// - over-temperature off until below hysteresis
// - shutdown below 1.25V latches gate off
// - soft-start, overload, PFC debounce from timer clock
// - burst stop disables, burst start resumes
`ifndef FPS_DEFS_VH
`define FPS_DEFS_VH

`define FPS_CLK_PERIOD_NS 8
`define FPS_BLANK_NS 350
`define FPS_AUX_SAMPLE_NS 2000
`define FPS_SCP_MS 16
`define FPS_RESTART_NS 10000

// timer clock ticks; real time follows the timer capacitor
`define FPS_SS_TICKS 46
`define FPS_OLP_TICKS 300
`define FPS_PFC_TICKS 4700

`define FPS_AUX_OVP_RUN 4
`define FPS_OLP_CROSSINGS 4
`define FPS_SYNC_W 16

`endif

// ### design/fps_sync.v
`timescale 1ns/1ps
`default_nettype none
module fps_sync #(
  parameter W = 16
) (
  // clock and reset
  input wire clk,
  input wire arst_n,
  // asynchronous levels in, filtered levels out
  input wire [W-1:0] din,
  output reg [W-1:0] dout
);
  reg [W-1:0] s1;
  reg [W-1:0] s2;
  reg [W-1:0] s3;
  integer i;

  // s1 feeds s2 only; a change is taken once s2 and s3 agree
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s1 <= {W{1'b0}};
      s2 <= {W{1'b0}};
      s3 <= {W{1'b0}};
      dout <= {W{1'b0}};
    end else begin
      s1 <= din;
      s2 <= s1;
      s3 <= s2;
      for (i = 0; i < W; i = i + 1) begin
        if (s2[i] == s3[i]) begin
          dout[i] <= s3[i];
        end
      end
    end
  end
endmodule
`default_nettype wire

// ### design/fps_top.v
`timescale 1ns/1ps
`default_nettype none
`include "fps_defs.vh"
module fps_top #(
  parameter SCP_CYC = (`FPS_SCP_MS * 1000000) / `FPS_CLK_PERIOD_NS,
  parameter OLP_TICKS = `FPS_OLP_TICKS,
  parameter SS_TICKS = `FPS_SS_TICKS,
  parameter PFC_TICKS = `FPS_PFC_TICKS
) (
  // clock and reset
  input wire clk,
  input wire arst_n,
  // comparator flags from the analog front end
  input wire sense_at_peak,
  input wire comp_above_offset_level,
  input wire high_line,
  input wire comp_at_overload,
  input wire aux_above_zcd,
  input wire aux_over_current,
  input wire vcc_at_turn_on,
  input wire vcc_above_turn_off,
  input wire vcc_below_pdr,
  input wire vcc_below_10v,
  input wire vcc_overvoltage,
  input wire temp_over_trip,
  input wire temp_below_hyst,
  input wire shutdown_input_low,
  input wire comp_below_burst_stop,
  input wire comp_above_burst_start,
  input wire timer_capacitor_clock,
  input wire pfc_light_load,
  // drive outputs
  output reg flyback_gate_drive,
  output reg offset_comp_enable,
  output reg pfc_turn_off,
  // status
  output reg overload_protect,
  output reg short_circuit_protect,
  output reg overvoltage_protect,
  output reg aux_overvoltage_protect,
  output reg shutdown_latched,
  output reg over_temp,
  output reg burst_off,
  output reg supply_lockout,
  output reg soft_start_active
);
  localparam BLANK_CYC = (`FPS_BLANK_NS + `FPS_CLK_PERIOD_NS - 1) / `FPS_CLK_PERIOD_NS;
  localparam AUX_CYC = (`FPS_AUX_SAMPLE_NS + `FPS_CLK_PERIOD_NS - 1) / `FPS_CLK_PERIOD_NS;
  localparam RESTART_CYC = (`FPS_RESTART_NS + `FPS_CLK_PERIOD_NS - 1) / `FPS_CLK_PERIOD_NS;
  localparam [1:0] ST_IDLE = 2'd0;
  localparam [1:0] ST_ON = 2'd1;
  localparam [1:0] ST_SAMPLE = 2'd2;

  wire [`FPS_SYNC_W-1:0] raw;
  wire [`FPS_SYNC_W-1:0] syn;
  wire [17:0] raw_all;
  assign raw = {sense_at_peak, aux_above_zcd, aux_over_current, vcc_at_turn_on,
                vcc_above_turn_off, vcc_below_pdr, vcc_below_10v, vcc_overvoltage,
                temp_over_trip, temp_below_hyst, shutdown_input_low,
                comp_below_burst_stop, comp_above_burst_start, timer_capacitor_clock,
                pfc_light_load, comp_at_overload};
  // the offset enable pair is qualified through a second stage set
  assign raw_all = {comp_above_offset_level, high_line, raw};
  wire [1:0] syn_ofs;

  fps_sync #(.W(`FPS_SYNC_W)) u_sync (
    .clk(clk),
    .arst_n(arst_n),
    .din(raw),
    .dout(syn)
  );
  fps_sync #(.W(2)) u_sync_ofs (
    .clk(clk),
    .arst_n(arst_n),
    .din(raw_all[17:16]),
    .dout(syn_ofs)
  );

  wire s_peak = syn[15];
  wire s_zcd = syn[14];
  wire s_aux_ov = syn[13];
  wire s_von = syn[12];
  wire s_voff_ok = syn[11];
  wire s_pdr = syn[10];
  wire s_v10 = syn[9];
  wire s_vovp = syn[8];
  wire s_ot = syn[7];
  wire s_cool = syn[6];
  wire s_sd = syn[5];
  wire s_bstop = syn[4];
  wire s_bstart = syn[3];
  wire s_ct = syn[2];
  wire s_light = syn[1];
  wire s_olp = syn[0];

  reg prev_zcd;
  reg prev_von;
  reg prev_voff_ok;
  reg prev_ct;
  wire zcd_fall = prev_zcd & ~s_zcd;
  wire von_rise = ~prev_von & s_von;
  wire voff_fall = prev_voff_ok & ~s_voff_ok;
  wire ct_tick = ~prev_ct & s_ct;

  reg pdr_seen;
  reg [1:0] olp_cross;
  reg [15:0] olp_cnt;
  reg [22:0] scp_cnt;
  reg [15:0] ss_cnt;
  reg [15:0] pfc_cnt;
  reg [1:0] state;
  reg [15:0] tmr;
  reg [2:0] ovp_run;

  wire any_fault = overload_protect | short_circuit_protect | overvoltage_protect |
                   aux_overvoltage_protect | shutdown_latched | over_temp;
  wire gate_allow = ~any_fault & ~supply_lockout & ~burst_off;
  // a clean retry at the turn-on level clears these; a persisting fault re-trips
  wire retry = von_rise;
  wire aux_sample = (state == ST_SAMPLE) && (tmr == AUX_CYC[15:0] - 16'h0001);
  wire aux_trip = aux_sample && s_aux_ov && (ovp_run == `FPS_AUX_OVP_RUN - 1);

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      prev_zcd <= 1'b0;
      prev_von <= 1'b0;
      prev_voff_ok <= 1'b0;
      prev_ct <= 1'b0;
    end else begin
      prev_zcd <= s_zcd;
      prev_von <= s_von;
      prev_voff_ok <= s_voff_ok;
      prev_ct <= s_ct;
    end
  end

  // protection state; in every flag the set term wins over its clear
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      offset_comp_enable <= 1'b0;
      supply_lockout <= 1'b1;
      burst_off <= 1'b0;
      over_temp <= 1'b0;
      overvoltage_protect <= 1'b0;
      short_circuit_protect <= 1'b0;
      shutdown_latched <= 1'b0;
      pdr_seen <= 1'b0;
      overload_protect <= 1'b0;
      olp_cross <= 2'd0;
      olp_cnt <= 16'h0000;
      scp_cnt <= 23'h000000;
    end else begin
      offset_comp_enable <= syn_ofs[1] & syn_ofs[0];
      if (!s_voff_ok) begin
        supply_lockout <= 1'b1;
      end else if (von_rise) begin
        supply_lockout <= 1'b0;
      end
      if (s_bstop) begin
        burst_off <= 1'b1;
      end else if (s_bstart) begin
        burst_off <= 1'b0;
      end
      if (s_ot) begin
        over_temp <= 1'b1;
      end else if (s_cool) begin
        over_temp <= 1'b0;
      end
      if (s_vovp) begin
        overvoltage_protect <= 1'b1;
      end else if (retry) begin
        overvoltage_protect <= 1'b0;
      end
      // latch stays through every turn-on until supply has dropped below reset level
      if (s_pdr) begin
        pdr_seen <= 1'b1;
      end else if (von_rise) begin
        pdr_seen <= 1'b0;
      end
      if (s_sd) begin
        shutdown_latched <= 1'b1;
      end else if (pdr_seen && von_rise) begin
        shutdown_latched <= 1'b0;
      end
      if (s_olp) begin
        if (ct_tick && olp_cnt != OLP_TICKS[15:0]) begin
          olp_cnt <= olp_cnt + 16'h0001;
        end
      end else begin
        olp_cnt <= 16'h0000;
      end
      if (s_olp && s_v10) begin
        if (scp_cnt != SCP_CYC[22:0]) begin
          scp_cnt <= scp_cnt + 23'h000001;
        end
      end else begin
        scp_cnt <= 23'h000000;
      end
      if (s_olp && s_v10 && scp_cnt == SCP_CYC[22:0]) begin
        short_circuit_protect <= 1'b1;
      end else if (retry) begin
        short_circuit_protect <= 1'b0;
      end
      if (s_olp && olp_cnt == OLP_TICKS[15:0]) begin
        overload_protect <= 1'b1;
        olp_cross <= 2'd0;
      end else if (overload_protect && voff_fall) begin
        olp_cross <= olp_cross + 2'd1;
        if (olp_cross == `FPS_OLP_CROSSINGS - 1) begin
          overload_protect <= 1'b0;
        end
      end
    end
  end

  // timer capacitor clock paces soft-start and the PFC light load debounce
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ss_cnt <= 16'h0000;
      soft_start_active <= 1'b0;
      pfc_cnt <= 16'h0000;
      pfc_turn_off <= 1'b0;
    end else begin
      if (von_rise) begin
        ss_cnt <= 16'h0000;
        soft_start_active <= 1'b1;
      end else if (soft_start_active && ct_tick) begin
        ss_cnt <= ss_cnt + 16'h0001;
        if (ss_cnt == SS_TICKS[15:0] - 16'h0001) begin
          soft_start_active <= 1'b0;
        end
      end
      if (!s_light) begin
        pfc_cnt <= 16'h0000;
        pfc_turn_off <= 1'b0;
      end else if (ct_tick && pfc_cnt != PFC_TICKS[15:0]) begin
        pfc_cnt <= pfc_cnt + 16'h0001;
      end else if (pfc_cnt == PFC_TICKS[15:0]) begin
        pfc_turn_off <= 1'b1;
      end
    end
  end

  // switching cycle; a valley edge arriving before the sample point is ignored
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= ST_IDLE;
      tmr <= 16'h0000;
      flyback_gate_drive <= 1'b0;
      ovp_run <= 3'd0;
      aux_overvoltage_protect <= 1'b0;
    end else begin
      if (aux_sample) begin
        if (s_aux_ov && !aux_trip) begin
          ovp_run <= ovp_run + 3'd1;
        end else begin
          ovp_run <= 3'd0;
        end
      end
      if (aux_trip) begin
        aux_overvoltage_protect <= 1'b1;
      end else if (retry) begin
        aux_overvoltage_protect <= 1'b0;
      end
      case (state)
        ST_IDLE: begin
          // restart timer covers start-up, when no valley edge exists yet
          if (tmr != RESTART_CYC[15:0]) begin
            tmr <= tmr + 16'h0001;
          end
          if (gate_allow && (zcd_fall || tmr == RESTART_CYC[15:0])) begin
            state <= ST_ON;
            flyback_gate_drive <= 1'b1;
            tmr <= 16'h0000;
          end
        end
        ST_ON: begin
          if (tmr != BLANK_CYC[15:0]) begin
            tmr <= tmr + 16'h0001;
          end
          if (!gate_allow || (s_peak && tmr == BLANK_CYC[15:0])) begin
            state <= ST_SAMPLE;
            flyback_gate_drive <= 1'b0;
            tmr <= 16'h0000;
          end
        end
        ST_SAMPLE: begin
          tmr <= tmr + 16'h0001;
          if (aux_sample) begin
            state <= ST_IDLE;
            tmr <= 16'h0000;
          end
        end
        default: begin
          state <= ST_IDLE;
          flyback_gate_drive <= 1'b0;
          tmr <= 16'h0000;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// ### design/fps_unused_placeholder_removed.v
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ### verification/fps_chk.sv
`timescale 1ns/1ps
`default_nettype none
module fps_chk (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // comparator flags
  input wire logic sense_at_peak,
  input wire logic comp_above_offset_level,
  input wire logic high_line,
  input wire logic comp_at_overload,
  input wire logic vcc_at_turn_on,
  input wire logic vcc_overvoltage,
  input wire logic comp_below_burst_stop,
  // outputs
  input wire logic flyback_gate_drive,
  input wire logic offset_comp_enable,
  input wire logic overload_protect,
  input wire logic short_circuit_protect,
  input wire logic overvoltage_protect,
  input wire logic aux_overvoltage_protect,
  input wire logic shutdown_latched,
  input wire logic over_temp,
  input wire logic burst_off,
  input wire logic supply_lockout
);
  wire logic blk = overload_protect | short_circuit_protect | overvoltage_protect |
    aux_overvoltage_protect | shutdown_latched | over_temp | burst_off | supply_lockout;
  int on_cnt;
  always @(posedge clk or negedge arst_n)
    if (!arst_n) on_cnt <= 0;
    else on_cnt <= flyback_gate_drive ? on_cnt + 1 : 0;
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  // windows allow 3-4 clk of input sync plus the output register
  a_block_gate_low:
    assert property (blk && $past(blk) |-> !flyback_gate_drive) else $error("gate on");
  a_offset_follows:
    assert property ($stable(comp_above_offset_level & high_line)[*7] |->
      offset_comp_enable == (comp_above_offset_level & high_line)) else $error("offset");
  a_peak_ends_on:
    assert property ($rose(sense_at_peak) && on_cnt > 50 |-> ##[1:7] !flyback_gate_drive)
      else $error("peak");
  a_blank_holds_gate:
    assert property ($rose(sense_at_peak) && on_cnt < 30 |-> flyback_gate_drive[*8])
      else $error("blanking");
  a_overload_cause:
    assert property ($rose(overload_protect) |-> $past(comp_at_overload, 5) &&
      $past(comp_at_overload, 12)) else $error("overload");
  a_supply_ov_sets:
    assert property (vcc_overvoltage[*7] |-> overvoltage_protect) else $error("supply ov");
  a_burst_stops:
    assert property (comp_below_burst_stop[*8] |-> burst_off && !flyback_gate_drive)
      else $error("burst");
  a_latch_release:
    assert property ($fell(shutdown_latched) |-> $past(vcc_at_turn_on) &&
      !$past(vcc_at_turn_on, 10)) else $error("latch");
  c_aux_trip: cover property ($rose(aux_overvoltage_protect));
  c_overload: cover property ($rose(overload_protect));
  c_latch: cover property ($fell(shutdown_latched));
endmodule
`default_nettype wire

// ### verification/fps_front.sv
`timescale 1ns/1ps
`default_nettype none
module fps_front (
  // clock and gate
  input wire logic clk,
  input wire logic gate,
  input wire logic [8:0] on_cyc,
  // comparator flags
  output logic sense_at_peak,
  output logic aux_above_zcd
);
  bit g_d;
  int n;
  // on_cyc sets the ramp: 20 lands inside blanking, 100 well past it
  always @(posedge clk) begin
    g_d <= gate;
    n <= (gate != g_d) ? 0 : n + 1;
    sense_at_peak <= gate && g_d && n >= on_cyc;
    aux_above_zcd <= !gate && (g_d || n < 300); // falls once demagnetised
  end
endmodule
`default_nettype wire

// ### verification/fps_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module fps_top_tb;
  logic clk, arst_n, sense_at_peak, comp_above_offset_level, high_line, comp_at_overload;
  logic aux_above_zcd, aux_over_current, vcc_at_turn_on, vcc_above_turn_off, vcc_below_pdr;
  logic vcc_below_10v, vcc_overvoltage, temp_over_trip, temp_below_hyst, shutdown_input_low;
  logic comp_below_burst_stop, comp_above_burst_start, timer_capacitor_clock, pfc_light_load;
  logic flyback_gate_drive, offset_comp_enable, pfc_turn_off, overload_protect;
  logic short_circuit_protect, overvoltage_protect, aux_overvoltage_protect, shutdown_latched;
  logic over_temp, burst_off, supply_lockout, soft_start_active;
  logic [8:0] on_cyc;
  int n_fail, n_compared, hi, lo;
  // short counts keep the run brief
  fps_top #(.SCP_CYC(200), .OLP_TICKS(5), .SS_TICKS(3), .PFC_TICKS(8)) dut_u (.*);
  fps_front mdl_u (.clk(clk), .gate(flyback_gate_drive), .on_cyc(on_cyc),
    .sense_at_peak(sense_at_peak), .aux_above_zcd(aux_above_zcd));
  initial begin
    clk = 0;
    forever #4 clk = ~clk;
  end
  // one timer tick every 10 clk
  initial begin
    timer_capacitor_clock = 0;
    #5;
    forever #40 timer_capacitor_clock = ~timer_capacitor_clock;
  end
  task automatic give_verdict;
    if (n_fail == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [8:0] e, input logic [8:0] g);
    n_compared++;
    if (g !== e) begin
      n_fail++;
      $display("FAIL %s expected %0d seen %0d", nm, e, g);
    end
  endtask
  task automatic w(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic cyc(input logic repower);
    vcc_at_turn_on = 0;
    vcc_above_turn_off = 0;
    vcc_below_pdr = repower;
    w(8);
    vcc_below_pdr = 0;
    vcc_above_turn_off = 1;
    w(8);
    vcc_at_turn_on = 1;
    w(8);
  endtask
  task automatic fall(input int k);
    repeat (k) @(negedge flyback_gate_drive);
    w(260);
  endtask
  task automatic on_len(input logic [8:0] c);
    on_cyc = c;
    @(posedge flyback_gate_drive);
    hi = 0;
    lo = 0;
    while (flyback_gate_drive === 1) begin
      w(1);
      hi++;
    end
    while (flyback_gate_drive !== 1) begin
      w(1);
      lo++;
    end
  endtask
  initial begin
    #400000;
    n_fail++;
    give_verdict();
  end
  initial begin
    {arst_n, comp_above_offset_level, high_line, comp_at_overload, aux_over_current} = '0;
    {vcc_at_turn_on, vcc_above_turn_off, vcc_below_pdr, vcc_below_10v, vcc_overvoltage} = '0;
    {temp_over_trip, temp_below_hyst, shutdown_input_low, comp_below_burst_stop} = '0;
    {comp_above_burst_start, pfc_light_load} = '0;
    on_cyc = 20;
    w(16);
    arst_n = 1;
    chk("lockout", 1, supply_lockout);
    w(8);
    cyc(0);
    chk("lockout", 0, supply_lockout);
    chk("soft_start", 1, soft_start_active);
    w(40);
    chk("soft_start", 0, soft_start_active);
    on_len(20);
    chk("on_fast", 1, hi >= 44 && hi <= 49);
    chk("off_time", 1, lo >= 300 && lo <= 312);
    on_len(100);
    chk("on_slow", 1, hi >= 100 && hi <= 112);
    comp_above_offset_level = 1;
    w(8);
    chk("offset", 0, offset_comp_enable);
    high_line = 1;
    w(8);
    chk("offset", 1, offset_comp_enable);
    aux_over_current = 1;
    fall(3);
    aux_over_current = 0;
    fall(1);
    aux_over_current = 1;
    fall(3);
    chk("aux_trip", 0, aux_overvoltage_protect);
    fall(1);
    chk("aux_trip", 1, aux_overvoltage_protect);
    aux_over_current = 0;
    cyc(0);
    chk("aux_trip", 0, aux_overvoltage_protect);
    fall(1);
    comp_below_burst_stop = 1;
    w(8);
    chk("burst", 1, burst_off);
    comp_below_burst_stop = 0;
    comp_above_burst_start = 1;
    w(8);
    chk("burst", 0, burst_off);
    comp_above_burst_start = 0;
    temp_over_trip = 1;
    w(8);
    temp_over_trip = 0;
    w(8);
    chk("temp", 1, over_temp);
    temp_below_hyst = 1;
    w(8);
    chk("temp", 0, over_temp);
    temp_below_hyst = 0;
    comp_at_overload = 1;
    w(30);
    chk("overload", 0, overload_protect);
    w(50);
    chk("overload", 1, overload_protect);
    chk("short", 0, short_circuit_protect);
    comp_at_overload = 0;
    repeat (3) cyc(0);
    chk("overload", 1, overload_protect);
    cyc(0);
    chk("overload", 0, overload_protect);
    comp_at_overload = 1;
    vcc_below_10v = 1;
    w(250);
    chk("short", 1, short_circuit_protect);
    comp_at_overload = 0;
    vcc_below_10v = 0;
    repeat (4) cyc(0);
    chk("short", 0, short_circuit_protect);
    vcc_overvoltage = 1;
    w(8);
    vcc_overvoltage = 0;
    w(8);
    chk("supply_ov", 1, overvoltage_protect);
    cyc(0);
    chk("supply_ov", 0, overvoltage_protect);
    shutdown_input_low = 1;
    w(8);
    shutdown_input_low = 0;
    cyc(0);
    chk("latch", 1, shutdown_latched);
    cyc(1);
    chk("latch", 0, shutdown_latched);
    pfc_light_load = 1;
    w(60);
    chk("pfc_off", 0, pfc_turn_off);
    w(40);
    chk("pfc_off", 1, pfc_turn_off);
    pfc_light_load = 0;
    w(8);
    chk("pfc_off", 0, pfc_turn_off);
    give_verdict();
  end
endmodule
bind fps_top fps_chk chk_u (.*);
`default_nettype wire
